// File: rtl/pmr_regs.sv
// Control registers for the core rail, two linear regulators and four
// open-drain general pins, plus low-power mode and pin interrupts.
// Assumes a serial interface engine on the same clock presents register
// accesses as one-cycle strobes; the general pins and the sleep request
// pin are asynchronous.
//
// How it works
// - Core rail code maps to eight voltages from 0.85 V to 1.8 V.
// - Regulator control at 0x0E, resets to 0x88, both regulators on.
// - Voltage select taken only while disabled or in the enabling write.
// - Regulator B off in every mode while its enable bit is clear.
// - Enabled: full power normally; in low power reduced, or off if sleep-off set.
// - Regulator A follows the same mapping with bits 3 and 2.
// - Regulator B bits 5-4 select 1.8, 2.5, 3.0 or 3.3 V.
// - Regulator A bits 1-0 select external level, 2.5, 2.75 or 3.0 V.
// - Pin interrupt config at 0x0F, resets 0x00, applies to input pins.
// - Bits 7-4 choose rising (1) or falling (0) edge per pin.
// - Bits 3-0 mask each pin interrupt when set; reset leaves unmasked.
// - Pin register at 0x10, resets 0x00; bits 7-4 set output direction.
// - Output value 1 pulls the pin low; 0 releases it.
// - Input pin value bit reads back the pin level.
// - Writes to value bits of input pins are ignored.
// - Low-power mode when sleep pin high and low-power enable set.
// - Low power forces rail code top bit 0, low bits from sleep field.
`timescale 1ns/1ps

module pmr_regs (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Register access from the serial interface engine
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             reg_hit_o,
  // Fields of the neighbouring converter registers, and the sleep request pin
  input  wire logic        sleep_enable_i,
  input  wire logic [2:0]  rail_code_i,
  input  wire logic [1:0]  sleep_rail_code_i,
  input  wire logic        sleep_request_pin_i,
  // Core rail
  output logic             low_power_mode_o,
  output logic      [2:0]  processor_rail_code_o,
  output logic      [11:0] processor_rail_mv_o,
  // Regulators
  output logic             regulator_a_on_o,
  output logic             regulator_a_reduced_o,
  output logic      [11:0] regulator_a_mv_o,
  output logic             regulator_a_external_o,
  output logic             regulator_b_on_o,
  output logic             regulator_b_reduced_o,
  output logic      [11:0] regulator_b_mv_o,
  // General pins, open drain
  input  wire logic [3:0]  general_pin_i,
  output logic      [3:0]  general_pin_o,
  output logic      [3:0]  general_pin_oe_o,
  // Pin interrupts
  input  wire logic [3:0]  pin_irq_clear_i,
  output logic      [3:0]  pin_irq_pending_o,
  output logic             pin_irq_o
);

  // ------------------------------------------------------------
  // Decode functions
  // ------------------------------------------------------------
  function automatic logic [11:0] rail_mv(input logic [2:0] code);
    case (code)
      3'h0:    rail_mv = pmr_pkg::MV_0850;
      3'h1:    rail_mv = pmr_pkg::MV_1000;
      3'h2:    rail_mv = pmr_pkg::MV_1100;
      3'h3:    rail_mv = pmr_pkg::MV_1200;
      3'h4:    rail_mv = pmr_pkg::MV_1300;
      3'h5:    rail_mv = pmr_pkg::MV_1400;
      3'h6:    rail_mv = pmr_pkg::MV_1500;
      default: rail_mv = pmr_pkg::MV_1800;
    endcase
  endfunction

  function automatic logic [11:0] reg_b_mv(input logic [1:0] sel);
    case (sel)
      2'h0:    reg_b_mv = pmr_pkg::MV_1800;
      2'h1:    reg_b_mv = pmr_pkg::MV_2500;
      2'h2:    reg_b_mv = pmr_pkg::MV_3000;
      default: reg_b_mv = pmr_pkg::MV_3300;
    endcase
  endfunction

  function automatic logic [11:0] reg_a_mv(input logic [1:0] sel);
    case (sel)
      2'h0:    reg_a_mv = pmr_pkg::MV_EXTERNAL;
      2'h1:    reg_a_mv = pmr_pkg::MV_2500;
      2'h2:    reg_a_mv = pmr_pkg::MV_2750;
      default: reg_a_mv = pmr_pkg::MV_3000;
    endcase
  endfunction

  // The enable/sleep-off table is the same for both regulators.
  function automatic logic [1:0] reg_state(input logic on, input logic sleep_off,
                                           input logic low_power);
    // Bit 1 is running, bit 0 is reduced power.
    if (!on) begin
      reg_state = 2'h0;
    end else if (!low_power) begin
      reg_state = 2'h2;
    end else if (sleep_off) begin
      reg_state = 2'h0;
    end else begin
      reg_state = 2'h3;
    end
  endfunction

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] regulator_control_r;
  logic [7:0] pin_interrupt_config_r;
  logic [3:0] pin_direction_r;
  logic [3:0] pin_value_r;
  logic [3:0] pin_sync1_r;
  logic [3:0] pin_sync2_r;
  logic [3:0] pin_sync3_r;
  logic [3:0] pin_level_r;
  logic [3:0] pin_irq_pending_r;
  logic [3:0] pin_warm_r;
  logic [2:0] sleep_sync_r;
  logic       sleep_level_r;
  logic [7:0] reg_rdata_r;

  logic       wr_regulator;
  logic       wr_irq_cfg;
  logic       wr_pins;
  logic [7:0] regulator_control_nxt;
  logic [3:0] pin_level_nxt;
  logic [3:0] pin_edge;
  logic       low_power;
  logic [1:0] reg_a_state;
  logic [1:0] reg_b_state;

  assign wr_regulator = reg_wr_i && (reg_addr_i == pmr_pkg::OFS_REGULATOR_CONTROL);
  assign wr_irq_cfg   = reg_wr_i && (reg_addr_i == pmr_pkg::OFS_PIN_INTERRUPT_CONFIG);
  assign wr_pins      = reg_wr_i && (reg_addr_i == pmr_pkg::OFS_PIN_DIRECTION_VALUE);

  // ------------------------------------------------------------
  // Regulator control
  // ------------------------------------------------------------
  // A running regulator keeps its voltage select, so a careless write cannot
  // step the output while it is loaded; software disables first or changes
  // the select in the very write that enables it.
  always_comb begin
    regulator_control_nxt = reg_wdata_i;
    if (regulator_control_r[pmr_pkg::REG_B_ON_BIT]) begin
      regulator_control_nxt[pmr_pkg::REG_B_SEL_LSB +: 2] =
        regulator_control_r[pmr_pkg::REG_B_SEL_LSB +: 2];
    end
    if (regulator_control_r[pmr_pkg::REG_A_ON_BIT]) begin
      regulator_control_nxt[pmr_pkg::REG_A_SEL_LSB +: 2] =
        regulator_control_r[pmr_pkg::REG_A_SEL_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      regulator_control_r <= pmr_pkg::RST_REGULATOR_CONTROL;
    end else if (wr_regulator) begin
      regulator_control_r <= regulator_control_nxt;
    end
  end

  assign reg_b_state = reg_state(regulator_control_r[pmr_pkg::REG_B_ON_BIT],
                                 regulator_control_r[pmr_pkg::REG_B_SLEEP_OFF_BIT],
                                 low_power);
  assign reg_a_state = reg_state(regulator_control_r[pmr_pkg::REG_A_ON_BIT],
                                 regulator_control_r[pmr_pkg::REG_A_SLEEP_OFF_BIT],
                                 low_power);

  assign regulator_b_on_o       = reg_b_state[1];
  assign regulator_b_reduced_o  = reg_b_state[0];
  assign regulator_a_on_o       = reg_a_state[1];
  assign regulator_a_reduced_o  = reg_a_state[0];
  assign regulator_b_mv_o =
    reg_b_mv(regulator_control_r[pmr_pkg::REG_B_SEL_LSB +: 2]);
  assign regulator_a_mv_o =
    reg_a_mv(regulator_control_r[pmr_pkg::REG_A_SEL_LSB +: 2]);
  assign regulator_a_external_o =
    (regulator_control_r[pmr_pkg::REG_A_SEL_LSB +: 2] == 2'h0);

  // ------------------------------------------------------------
  // Low-power mode and core rail
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sleep_sync_r  <= 3'h0;
      sleep_level_r <= 1'b0;
    end else begin
      sleep_sync_r <= {sleep_sync_r[1:0], sleep_request_pin_i};
      if (sleep_sync_r[1] == sleep_sync_r[2]) begin
        sleep_level_r <= sleep_sync_r[2];
      end
    end
  end

  assign low_power        = sleep_level_r && sleep_enable_i;
  assign low_power_mode_o = low_power;
  assign processor_rail_code_o =
    low_power ? {1'b0, sleep_rail_code_i} : rail_code_i;
  assign processor_rail_mv_o = rail_mv(processor_rail_code_o);

  // ------------------------------------------------------------
  // Pin interrupt configuration
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_interrupt_config_r <= pmr_pkg::RST_PIN_INTERRUPT_CONFIG;
    end else if (wr_irq_cfg) begin
      pin_interrupt_config_r <= reg_wdata_i;
    end
  end

  // ------------------------------------------------------------
  // General pins
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_direction_r <= pmr_pkg::RST_PIN_DIRECTION_VALUE[pmr_pkg::PIN_HIGH_LSB +: 4];
    end else if (wr_pins) begin
      pin_direction_r <= reg_wdata_i[pmr_pkg::PIN_HIGH_LSB +: 4];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_sync1_r <= 4'h0;
      pin_sync2_r <= 4'h0;
      pin_sync3_r <= 4'h0;
      pin_level_r <= 4'h0;
    end else begin
      pin_sync1_r <= general_pin_i;
      pin_sync2_r <= pin_sync1_r;
      pin_sync3_r <= pin_sync2_r;
      pin_level_r <= pin_level_nxt;
    end
  end

  // Edges are ignored until the filter holds a real pin level. The level flops
  // reset low, so a pulled-up pin would otherwise look like a rising edge.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_warm_r <= 4'h0;
    end else begin
      pin_warm_r <= {pin_warm_r[2:0], 1'b1};
    end
  end

  generate
    for (genvar p = 0; p < pmr_pkg::PIN_COUNT; p++) begin : g_pin
      // A level counts only once two stages agree, filtering a half-settled edge.
      assign pin_level_nxt[p] =
        (pin_sync2_r[p] == pin_sync3_r[p]) ? pin_sync3_r[p] : pin_level_r[p];

      // Value bits of input pins keep their stored value; writes there are dropped.
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          pin_value_r[p] <= pmr_pkg::RST_PIN_DIRECTION_VALUE[pmr_pkg::PIN_LOW_LSB + p];
        end else if (wr_pins && pin_direction_r[p]) begin
          pin_value_r[p] <= reg_wdata_i[pmr_pkg::PIN_LOW_LSB + p];
        end
      end

      // Open drain: the pad only ever pulls low.
      assign general_pin_o[p]    = 1'b0;
      assign general_pin_oe_o[p] = pin_direction_r[p] && pin_value_r[p];

      assign pin_edge[p] = pin_warm_r[3] && !pin_direction_r[p] &&
        (pin_level_nxt[p] != pin_level_r[p]) &&
        (pin_level_nxt[p] == pin_interrupt_config_r[pmr_pkg::PIN_HIGH_LSB + p]);

      // A new edge in the clearing cycle keeps the flag set.
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          pin_irq_pending_r[p] <= 1'b0;
        end else if (pin_edge[p] &&
                     !pin_interrupt_config_r[pmr_pkg::PIN_LOW_LSB + p]) begin
          pin_irq_pending_r[p] <= 1'b1;
        end else if (pin_irq_clear_i[p]) begin
          pin_irq_pending_r[p] <= 1'b0;
        end
      end
    end
  endgenerate

  assign pin_irq_pending_o = pin_irq_pending_r;
  assign pin_irq_o         = |pin_irq_pending_r;

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  logic [3:0] pin_value_view;
  assign pin_value_view = (pin_direction_r & pin_value_r) |
                          (~pin_direction_r & pin_level_r);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        pmr_pkg::OFS_REGULATOR_CONTROL:    reg_rdata_r <= regulator_control_r;
        pmr_pkg::OFS_PIN_INTERRUPT_CONFIG: reg_rdata_r <= pin_interrupt_config_r;
        pmr_pkg::OFS_PIN_DIRECTION_VALUE:  reg_rdata_r <= {pin_direction_r, pin_value_view};
        default:                           reg_rdata_r <= 8'h00;
      endcase
    end
  end

  assign reg_rdata_o = reg_rdata_r;
  assign reg_hit_o   = (reg_addr_i == pmr_pkg::OFS_REGULATOR_CONTROL) ||
                       (reg_addr_i == pmr_pkg::OFS_PIN_INTERRUPT_CONFIG) ||
                       (reg_addr_i == pmr_pkg::OFS_PIN_DIRECTION_VALUE);

endmodule

// File: rtl/pmr_pkg.sv
// Constants shared by the power-management register bank.
// Assumes nothing of its surroundings; holds definitions only.
package pmr_pkg;

  // ------------------------------------------------------------
  // Register offsets and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_REGULATOR_CONTROL    = 8'h0E;
  localparam logic [7:0] OFS_PIN_INTERRUPT_CONFIG = 8'h0F;
  localparam logic [7:0] OFS_PIN_DIRECTION_VALUE  = 8'h10;

  localparam logic [7:0] RST_REGULATOR_CONTROL    = 8'h88;
  localparam logic [7:0] RST_PIN_INTERRUPT_CONFIG = 8'h00;
  localparam logic [7:0] RST_PIN_DIRECTION_VALUE  = 8'h00;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int REG_B_ON_BIT        = 7;
  localparam int REG_B_SLEEP_OFF_BIT = 6;
  localparam int REG_B_SEL_LSB       = 4;
  localparam int REG_A_ON_BIT        = 3;
  localparam int REG_A_SLEEP_OFF_BIT = 2;
  localparam int REG_A_SEL_LSB       = 0;
  localparam int PIN_HIGH_LSB        = 4;
  localparam int PIN_LOW_LSB         = 0;
  localparam int PIN_COUNT           = 4;
  localparam int READ_DATA_ZERO      = 0;

  // ------------------------------------------------------------
  // Voltages in millivolts
  // ------------------------------------------------------------
  localparam logic [11:0] MV_0850 = 12'h352;
  localparam logic [11:0] MV_1000 = 12'h3E8;
  localparam logic [11:0] MV_1100 = 12'h44C;
  localparam logic [11:0] MV_1200 = 12'h4B0;
  localparam logic [11:0] MV_1300 = 12'h514;
  localparam logic [11:0] MV_1400 = 12'h578;
  localparam logic [11:0] MV_1500 = 12'h5DC;
  localparam logic [11:0] MV_1800 = 12'h708;
  localparam logic [11:0] MV_2500 = 12'h9C4;
  localparam logic [11:0] MV_2750 = 12'hABE;
  localparam logic [11:0] MV_3000 = 12'hBB8;
  localparam logic [11:0] MV_3300 = 12'hCE4;
  // Reported for the externally set level, which has no fixed figure.
  localparam logic [11:0] MV_EXTERNAL = 12'h000;

endpackage

// File: tb/pmr_regs_asserts.sv
// Port-level checker for the register bank.
// Assumes one clock and the active-low asynchronous reset of the bank.
`timescale 1ns/1ps
module pmr_regs_asserts (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  // Register port and neighbour fields
  input wire logic [7:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        reg_hit_o,
  input wire logic        sleep_enable_i,
  input wire logic [1:0]  sleep_rail_code_i,
  input wire logic [2:0]  rail_code_i,
  // Outputs under watch, and the interrupt clear input
  input wire logic        low_power_mode_o,
  input wire logic [2:0]  processor_rail_code_o,
  input wire logic [11:0] processor_rail_mv_o,
  input wire logic        regulator_a_on_o,
  input wire logic        regulator_a_reduced_o,
  input wire logic [11:0] regulator_a_mv_o,
  input wire logic        regulator_a_external_o,
  input wire logic        regulator_b_on_o,
  input wire logic        regulator_b_reduced_o,
  input wire logic [3:0]  general_pin_o,
  input wire logic [3:0]  pin_irq_clear_i,
  input wire logic [3:0]  pin_irq_pending_o,
  input wire logic        pin_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence ctl_wr;
    reg_wr_i && reg_addr_i == pmr_pkg::OFS_REGULATOR_CONTROL;
  endsequence
  regb_off_a: assert property (ctl_wr ##0 !reg_wdata_i[7] |=> !regulator_b_on_o)
    else $error("regulator b on after disabling write");
  rega_off_a: assert property (ctl_wr ##0 !reg_wdata_i[3] |=> !regulator_a_on_o)
    else $error("regulator a on after disabling write");
  rega_reduced_a: assert property (
      regulator_a_reduced_o |-> low_power_mode_o && regulator_a_on_o)
    else $error("regulator a reduced outside low power");
  regb_reduced_a: assert property (
      regulator_b_reduced_o |-> low_power_mode_o && regulator_b_on_o)
    else $error("regulator b reduced outside low power");
  rail_code_a: assert property (
      processor_rail_code_o == (low_power_mode_o ? {1'b0, sleep_rail_code_i} : rail_code_i))
    else $error("core rail code wrong");
  rail_top_a: assert property (
      processor_rail_code_o == 3'h7 |-> processor_rail_mv_o == pmr_pkg::MV_1800)
    else $error("core rail top code voltage wrong");
  sleep_gate_a: assert property (!sleep_enable_i |-> !low_power_mode_o)
    else $error("low power without enable");
  irq_or_a: assert property (pin_irq_o == |pin_irq_pending_o)
    else $error("interrupt request not the or of pending");
  pend_hold_a: assert property (
      &(~$past(pin_irq_pending_o) | pin_irq_pending_o | $past(pin_irq_clear_i)))
    else $error("pending dropped without clear");
  drain_zero_a: assert property (general_pin_o == 4'h0)
    else $error("pin driven high");
  ext_level_a: assert property (
      regulator_a_external_o |-> regulator_a_mv_o == pmr_pkg::MV_EXTERNAL)
    else $error("external level voltage wrong");
  unmapped_rd_a: assert property (reg_rd_i && !reg_hit_o |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind pmr_regs pmr_regs_asserts chk_u (.*);

// File: tb/pmr_pin_env.sv
// Board model around the general pins: pull-ups and outside pull-down sources.
// Assumes the device sinks a pin while its output enable is high.
`timescale 1ns/1ps
module pmr_pin_env (
  // Device side
  input  wire logic [3:0] oe_i,
  input  wire logic [3:0] drive_i,
  // Outside pull-downs commanded by the bench
  input  wire logic [3:0] ext_low_i,
  // Wire level back to the device
  output logic      [3:0] level_o
);
  // A released wire shows the pull-up, never a stale value.
  assign level_o = ~ext_low_i & ~(oe_i & ~drive_i);
endmodule

// File: tb/pmr_regs_tb.sv
// Self-checking bench for the register bank.
// Assumes the pin board model and the bound port checker.
`timescale 1ns/1ps
module pmr_regs_tb;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic sleep_enable_i = 1'b0;
  logic [2:0] rail_code_i = 3'h0;
  logic [1:0] sleep_rail_code_i = 2'h0;
  logic sleep_request_pin_i = 1'b0;
  logic [3:0] ext_low = 4'h8;
  logic [3:0] pin_irq_clear_i = 4'h0;
  logic [7:0] reg_rdata_o;
  logic [11:0] rail_mv, a_mv, b_mv;
  logic [3:0] pin_lvl, pin_o, pin_oe, pend;
  logic reg_hit, lp, a_on, a_red, a_ext, b_on, b_red, irq;
  logic [2:0] rail_code;
  int fail_count = 0;
  int checked = 0;
  int i;
  localparam logic [7:0] CTL = pmr_pkg::OFS_REGULATOR_CONTROL;
  localparam logic [7:0] CFG = pmr_pkg::OFS_PIN_INTERRUPT_CONFIG;
  localparam logic [7:0] PIN = pmr_pkg::OFS_PIN_DIRECTION_VALUE;
  logic [11:0] bt [4] = '{pmr_pkg::MV_1800, pmr_pkg::MV_2500, pmr_pkg::MV_3000, pmr_pkg::MV_3300};
  logic [11:0] at [4] = '{pmr_pkg::MV_EXTERNAL, pmr_pkg::MV_2500, pmr_pkg::MV_2750,
                          pmr_pkg::MV_3000};
  logic [11:0] rt [8] = '{pmr_pkg::MV_0850, pmr_pkg::MV_1000, pmr_pkg::MV_1100, pmr_pkg::MV_1200,
                          pmr_pkg::MV_1300, pmr_pkg::MV_1400, pmr_pkg::MV_1500, pmr_pkg::MV_1800};
  initial forever #4 clk_i = ~clk_i;
  pmr_regs dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit), .sleep_enable_i(sleep_enable_i),
    .rail_code_i(rail_code_i), .sleep_rail_code_i(sleep_rail_code_i),
    .sleep_request_pin_i(sleep_request_pin_i), .low_power_mode_o(lp),
    .processor_rail_code_o(rail_code), .processor_rail_mv_o(rail_mv),
    .regulator_a_on_o(a_on), .regulator_a_reduced_o(a_red), .regulator_a_mv_o(a_mv),
    .regulator_a_external_o(a_ext), .regulator_b_on_o(b_on), .regulator_b_reduced_o(b_red),
    .regulator_b_mv_o(b_mv), .general_pin_i(pin_lvl), .general_pin_o(pin_o),
    .general_pin_oe_o(pin_oe), .pin_irq_clear_i(pin_irq_clear_i),
    .pin_irq_pending_o(pend), .pin_irq_o(irq));
  pmr_pin_env env_u (.oe_i(pin_oe), .drive_i(pin_o), .ext_low_i(ext_low), .level_o(pin_lvl));
  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(nm, {4'h0, e}, {4'h0, reg_rdata_o});
  endtask
  task automatic wait_pend(input logic [3:0] e);
    int n;
    n = 0;
    while (pend !== e && n < 12) begin
      @(posedge clk_i);
      #1 n++;
    end
    chk("pending", {8'h0, e}, {8'h0, pend});
    if (n == 12) final_report();
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(CTL, 8'h88, "reg_ctl");
    rd(CFG, 8'h00, "irq_cfg");
    // Input pins read their pulled-up or held-low level, not the stored zero.
    rd(PIN, 8'h07, "pin_reg");
    rd(8'h11, 8'h00, "unmapped");
    chk("hit", 12'h0, {11'h0, reg_hit});
    chk("b_mv", pmr_pkg::MV_1800, b_mv);
    chk("a_ext", 12'h1, {11'h0, a_ext});
    $display("test reset done");
    wr(CTL, 8'h99);
    rd(CTL, 8'h88, "sel_kept");
    for (i = 0; i < 4; i++) begin
      wr(CTL, 8'h00);
      chk("both_off", 12'h0, {10'h0, a_on, b_on});
      // Regulator A is only ever stepped while off, never raised while running.
      wr(CTL, {2'b10, i[1:0], 2'b10, i[1:0]});
      chk("b_mv", bt[i], b_mv);
      chk("a_mv", at[i], a_mv);
    end
    $display("test voltage select done");
    for (i = 0; i < 8; i++) begin
      @(posedge clk_i);
      rail_code_i <= i[2:0];
      #1 chk("rail_mv", rt[i], rail_mv);
    end
    wr(CTL, 8'h00);
    wr(CTL, 8'hC8);
    @(posedge clk_i);
    sleep_request_pin_i <= 1'b1;
    sleep_rail_code_i <= 2'h2;
    repeat (6) @(posedge clk_i);
    #1 chk("lp_gated", 12'h0, {11'h0, lp});
    @(posedge clk_i);
    sleep_enable_i <= 1'b1;
    #1 chk("lp_on", 12'h1, {11'h0, lp});
    chk("lp_rail", pmr_pkg::MV_1100, rail_mv);
    chk("lp_regs", 12'h3, {9'h0, b_on, a_on, a_red});
    // Swap the sleep-off bits: B now runs reduced and A goes off.
    wr(CTL, 8'h8C);
    chk("lp_regs2", 12'hC, {8'h0, b_on, b_red, a_on, a_red});
    @(posedge clk_i);
    sleep_request_pin_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1 chk("normal_rail", 12'h7, {9'h0, rail_code});
    chk("normal_regs", 12'hA, {8'h0, b_on, b_red, a_on, a_red});
    $display("test low power done");
    // All pins are inputs before this write, so its value bits are dropped.
    wr(PIN, 8'h3F);
    rd(PIN, 8'h34, "pin_rd");
    chk("pin_oe", 12'h0, {8'h0, pin_oe});
    wr(PIN, 8'h31);
    rd(PIN, 8'h35, "pin_rd2");
    chk("pin_oe2", 12'h1, {8'h0, pin_oe});
    chk("pin_o", 12'h0, {8'h0, pin_o});
    $display("test pins done");
    @(posedge clk_i);
    pin_irq_clear_i <= 4'hF;
    wr(CFG, 8'h40);
    pin_irq_clear_i <= 4'h0;
    wait_pend(4'h0);
    @(posedge clk_i);
    ext_low <= 4'hC;
    repeat (8) @(posedge clk_i);
    #1 chk("wrong_edge", 12'h0, {8'h0, pend});
    @(posedge clk_i);
    ext_low <= 4'h8;
    wait_pend(4'h4);
    chk("irq", 12'h1, {11'h0, irq});
    @(posedge clk_i);
    pin_irq_clear_i <= 4'h4;
    @(posedge clk_i);
    pin_irq_clear_i <= 4'h0;
    #1 chk("cleared", 12'h0, {8'h0, pend});
    wr(CFG, 8'h04);
    ext_low <= 4'hC;
    repeat (8) @(posedge clk_i);
    #1 chk("masked", 12'h0, {8'h0, pend});
    wr(CFG, 8'h00);
    ext_low <= 4'h8;
    repeat (8) @(posedge clk_i);
    #1 chk("rise_ignored", 12'h0, {8'h0, pend});
    @(posedge clk_i);
    ext_low <= 4'hC;
    wait_pend(4'h4);
    $display("test interrupts done");
    final_report();
  end
endmodule
